// ---- hw/tw_core.sv ----
`default_nettype none
`include "tw_regs.svh"
module tw_core
    import tw_pkg::*;
(
    // Clock and reset
    input  wire logic    clk,
    input  wire logic    rst_n,
    // Processor register port
    input  wire tw_req_t req,
    input  wire logic    gie,
    output logic [7:0]   rdata,
    output logic         irq,
    // Bus pins
    input  wire logic    scl_in,
    input  wire logic    sda_in,
    output logic         scl_out,
    output logic         scl_oe,
    output logic         sda_out,
    output logic         sda_oe
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [2:0]  scl_sync_reg;
    logic [2:0]  sda_sync_reg;
    logic        scl_f_reg;
    logic        sda_f_reg;
    logic        scl_p_reg;
    logic        sda_p_reg;
    logic        busy_reg;
    logic [7:0]  brd_reg;
    tw_ctl_t     ctl_reg;
    tw_ctl_t     ctl_next;
    logic [1:0]  ps_reg;
    logic [4:0]  code_reg;
    logic [4:0]  evt_reg;
    logic [7:0]  dat_reg;
    logic [7:0]  dat_next;
    logic [7:0]  adr_reg;
    logic [6:0]  msk_reg;
    tw_state_t   st_reg;
    tw_state_t   st_n;
    logic        mst_reg;
    logic        mst_n;
    logic        slv_reg;
    logic        slv_n;
    logic        tx_reg;
    logic        tx_n;
    logic        adr_ph_reg;
    logic        adr_ph_n;
    logic        gc_reg;
    logic        gc_n;
    logic        lost_reg;
    logic        lost_n;
    logic        rs_reg;
    logic        rs_n;
    logic        ackrx_reg;
    logic        ackrx_n;
    logic [3:0]  cnt_reg;
    logic [3:0]  cnt_n;
    logic [14:0] tmr_reg;
    logic [14:0] tmr_n;
    logic        scl_lo_reg;
    logic        scl_lo_n;
    logic        sda_lo_reg;
    logic        sda_lo_n;
    logic        zero_reg;
    logic [7:0]  rdata_reg;
    logic [7:0]  rdata_next;
    logic        irq_reg;
    logic        shift;
    logic        set_flag;
    logic [4:0]  set_code;
    logic        sto_done;

    // ----------------------------------------
    // Pin conditioning and bus monitor
    // ----------------------------------------
    wire logic scl_f_next = (scl_sync_reg[1] == scl_sync_reg[2]) ? scl_sync_reg[2] : scl_f_reg;
    wire logic sda_f_next = (sda_sync_reg[1] == sda_sync_reg[2]) ? sda_sync_reg[2] : sda_f_reg;
    wire logic scl_rise   = scl_f_reg & ~scl_p_reg;
    wire logic scl_fall   = ~scl_f_reg & scl_p_reg;
    wire logic start_det  = scl_f_reg & scl_p_reg & ~sda_f_reg & sda_p_reg;
    wire logic stop_det   = scl_f_reg & scl_p_reg & sda_f_reg & ~sda_p_reg;
    wire logic busy_next  = start_det | (busy_reg & ~stop_det);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
            scl_f_reg    <= 1'b1;
            sda_f_reg    <= 1'b1;
            scl_p_reg    <= 1'b1;
            sda_p_reg    <= 1'b1;
            busy_reg     <= 1'b0;
        end else begin
            scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
            sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
            scl_f_reg    <= scl_f_next;
            sda_f_reg    <= sda_f_next;
            scl_p_reg    <= scl_f_reg;
            sda_p_reg    <= sda_f_reg;
            busy_reg     <= busy_next;
        end
    end

    // ----------------------------------------
    // Register decode
    // ----------------------------------------
    wire logic wr_brd = req.wr && (req.idx == `TW_IDX_BRD);
    wire logic wr_ctl = req.wr && (req.idx == `TW_IDX_CTL);
    wire logic wr_sts = req.wr && (req.idx == `TW_IDX_STS);
    wire logic wr_dat = req.wr && (req.idx == `TW_IDX_DAT);
    wire logic wr_adr = req.wr && (req.idx == `TW_IDX_ADR);
    wire logic wr_msk = req.wr && (req.idx == `TW_IDX_MSK);
    wire logic [7:0] wd = req.wdata;

    // A new event wins over a software clear in the same cycle.
    wire logic flag_next = set_flag | (ctl_reg.flag & ~(wr_ctl & wd[`TW_CTL_FLAG])); // RULE_04

    assign ctl_next = '{
        flag: flag_next,
        ack:  wr_ctl ? wd[`TW_CTL_ACK] : ctl_reg.ack,
        sta:  wr_ctl ? wd[`TW_CTL_STA] : ctl_reg.sta,
        sto:  wr_ctl ? wd[`TW_CTL_STO] : (ctl_reg.sto & ~sto_done),
        wc:   wr_dat ? ~ctl_reg.flag : ctl_reg.wc, // RULE_11
        en:   wr_ctl ? wd[`TW_CTL_EN] : ctl_reg.en,
        ie:   wr_ctl ? wd[`TW_CTL_IE] : ctl_reg.ie
    };

    assign dat_next = shift ? {dat_reg[6:0], sda_f_reg} : // RULE_18
                      (wr_dat && ctl_reg.flag) ? wd : dat_reg; // RULE_17

    assign rdata_next =
        (req.idx == `TW_IDX_BRD) ? brd_reg :
        (req.idx == `TW_IDX_CTL) ? {ctl_reg.flag, ctl_reg.ack, ctl_reg.sta, ctl_reg.sto,
                                    ctl_reg.wc, ctl_reg.en, 1'b0, ctl_reg.ie} :
        (req.idx == `TW_IDX_STS) ? {code_reg, 1'b0, ps_reg} : // RULE_14
        (req.idx == `TW_IDX_DAT) ? dat_reg :
        (req.idx == `TW_IDX_ADR) ? adr_reg :
        (req.idx == `TW_IDX_MSK) ? {msk_reg, 1'b0} : 8'h00;

    // ----------------------------------------
    // Bit rate, address match and event codes
    // ----------------------------------------
    wire logic [2:0]  ps_shamt = {ps_reg, 1'b0}; // RULE_16
    wire logic [14:0] half_cyc = `TW_HALF_FIXED + (15'(brd_reg) << ps_shamt); // RULE_01 RULE_24
    wire logic        tmr_done = (tmr_reg <= 15'h0001); // RULE_24
    wire logic own_hit = (((dat_reg[7:1] ^ adr_reg[7:1]) & ~msk_reg) == 7'h00); // RULE_20 RULE_22
    wire logic gc_hit  = adr_reg[0] && (dat_reg[7:1] == 7'h00); // RULE_21
    wire logic hit     = ctl_reg.ack && (own_hit || gc_hit); // RULE_07
    wire logic ack_in  = ~ackrx_reg;
    wire logic [4:0] mst_code =
        adr_ph_reg ? (dat_reg[0] ? (ack_in ? `TW_SC_MR_SLA_A : `TW_SC_MR_SLA_N)
                                 : (ack_in ? `TW_SC_MT_SLA_A : `TW_SC_MT_SLA_N)) :
        tx_reg     ? (ack_in ? `TW_SC_MT_DAT_A : `TW_SC_MT_DAT_N) :
                     (sda_lo_reg ? `TW_SC_MR_DAT_A : `TW_SC_MR_DAT_N);
    wire logic [4:0] slv_code =
        adr_ph_reg ? (dat_reg[0] ? `TW_SC_ST_SLA : gc_reg ? `TW_SC_SR_GC : `TW_SC_SR_SLA) :
        tx_reg     ? (ack_in ? `TW_SC_ST_DAT_A : `TW_SC_ST_DAT_N) :
                     (sda_lo_reg ? `TW_SC_SR_DAT_A : `TW_SC_SR_DAT_N);
    wire logic [4:0] done_code = (lost_reg && !slv_reg) ? `TW_SC_ARB_LOST : // RULE_19
                                 mst_reg ? mst_code : slv_code;
    wire logic go_byte = mst_reg || (!lost_reg && (adr_ph_reg || (slv_reg && !(tx_reg && ackrx_reg))));

    // ----------------------------------------
    // Bus engine
    // ----------------------------------------
    always_comb begin
        st_n     = st_reg;
        mst_n    = mst_reg;
        slv_n    = slv_reg;
        tx_n     = tx_reg;
        adr_ph_n = adr_ph_reg;
        gc_n     = gc_reg;
        lost_n   = lost_reg;
        rs_n     = rs_reg;
        ackrx_n  = ackrx_reg;
        cnt_n    = cnt_reg;
        shift    = 1'b0;
        tmr_n    = tmr_done ? tmr_reg : tmr_reg - 15'h0001;
        scl_lo_n = scl_lo_reg;
        sda_lo_n = sda_lo_reg;
        set_flag = 1'b0;
        set_code = `TW_SC_NONE;
        sto_done = 1'b0;
        case (st_reg)
            TW_IDLE: begin
                scl_lo_n = 1'b0;
                sda_lo_n = 1'b0;
                if (start_det) begin
                    st_n     = TW_BYTE;
                    adr_ph_n = 1'b1;
                    cnt_n    = 4'h0;
                    tx_n     = 1'b0;
                    mst_n    = 1'b0;
                end else if (ctl_reg.sta && !ctl_reg.flag && !busy_reg) begin // RULE_08
                    st_n     = TW_START;
                    sda_lo_n = 1'b1;
                    tmr_n    = half_cyc;
                    rs_n     = 1'b0;
                end
            end
            TW_START: begin
                if (tmr_done) begin
                    scl_lo_n = 1'b1;
                    st_n     = TW_HOLD;
                    mst_n    = 1'b1;
                    tx_n     = 1'b1;
                    adr_ph_n = 1'b1;
                    set_flag = 1'b1;
                    set_code = rs_reg ? `TW_SC_RSTART : `TW_SC_START;
                end
            end
            TW_RSTART: begin
                if (scl_lo_reg) begin
                    if (tmr_done) begin
                        scl_lo_n = 1'b0;
                        tmr_n    = half_cyc;
                    end
                end else if (!scl_f_reg) begin
                    tmr_n = half_cyc;
                end else if (tmr_done) begin
                    st_n     = TW_START;
                    sda_lo_n = 1'b1;
                    tmr_n    = half_cyc;
                    rs_n     = 1'b1;
                end
            end
            TW_HOLD: begin
                scl_lo_n = 1'b1; // RULE_03
                if (!ctl_reg.flag) begin // RULE_05
                    tmr_n  = half_cyc;
                    cnt_n  = 4'h0;
                    lost_n = 1'b0;
                    if (mst_reg && ctl_reg.sto) begin
                        st_n     = TW_STOP1;
                        sda_lo_n = 1'b1;
                    end else if (mst_reg && ctl_reg.sta) begin
                        st_n     = TW_RSTART;
                        sda_lo_n = 1'b0;
                    end else if (go_byte) begin
                        st_n     = TW_BYTE;
                        sda_lo_n = tx_reg & ~dat_reg[7];
                        scl_lo_n = mst_reg;
                    end else begin
                        st_n     = TW_IDLE;
                        slv_n    = 1'b0;
                        scl_lo_n = 1'b0;
                        sda_lo_n = 1'b0;
                    end
                end
            end
            TW_BYTE: begin
                if (!mst_reg) begin
                    scl_lo_n = 1'b0;
                end else if (scl_lo_reg) begin
                    if (tmr_done) begin
                        scl_lo_n = 1'b0;
                        tmr_n    = half_cyc;
                    end
                end else if (!scl_f_reg) begin
                    tmr_n = half_cyc;
                end else if (tmr_done) begin
                    scl_lo_n = 1'b1;
                    tmr_n    = half_cyc;
                end
                if (!mst_reg && (stop_det || start_det)) begin
                    sda_lo_n = 1'b0;
                    slv_n    = 1'b0;
                    adr_ph_n = start_det;
                    cnt_n    = 4'h0;
                    tx_n     = 1'b0;
                    st_n     = start_det ? TW_BYTE : TW_IDLE;
                    if (slv_reg && !adr_ph_reg) begin
                        st_n     = TW_HOLD;
                        scl_lo_n = 1'b1; // RULE_03
                        set_flag = 1'b1;
                        set_code = `TW_SC_SR_STOP;
                    end
                end else if (scl_rise) begin
                    if (cnt_reg < 4'h8) begin
                        shift = 1'b1; // RULE_18
                        cnt_n = cnt_reg + 4'h1;
                        if (mst_reg && tx_reg && !sda_lo_reg && !sda_f_reg) begin // RULE_19
                            mst_n    = 1'b0;
                            tx_n     = 1'b0;
                            lost_n   = 1'b1;
                            scl_lo_n = 1'b0;
                        end
                    end else begin
                        ackrx_n = sda_f_reg; // RULE_19
                        cnt_n   = 4'h9;
                    end
                end else if (scl_fall) begin
                    if (cnt_reg < 4'h8) begin
                        sda_lo_n = tx_reg & ~dat_reg[7];
                    end else if (cnt_reg == 4'h8) begin
                        if (adr_ph_reg && !mst_reg) begin
                            sda_lo_n = hit; // RULE_06
                            if (hit) begin
                                slv_n = 1'b1;
                                gc_n  = gc_hit && !own_hit;
                                tx_n  = dat_reg[0];
                            end else if (!lost_reg) begin
                                st_n     = TW_IDLE;
                                adr_ph_n = 1'b0;
                            end
                        end else begin
                            sda_lo_n = !tx_reg && !lost_reg && ctl_reg.ack; // RULE_06
                        end
                    end else begin
                        sda_lo_n = 1'b0;
                        cnt_n    = 4'h0;
                        adr_ph_n = 1'b0;
                        st_n     = TW_HOLD;
                        set_flag = 1'b1; // RULE_02 RULE_21
                        scl_lo_n = 1'b1; // RULE_03
                        set_code = done_code;
                        if (mst_reg && adr_ph_reg) begin
                            tx_n = ~dat_reg[0];
                        end
                    end
                end
            end
            TW_STOP1: begin
                if (tmr_done) begin
                    scl_lo_n = 1'b0;
                    tmr_n    = half_cyc;
                    st_n     = TW_STOP2;
                end
            end
            TW_STOP2: begin
                if (!scl_f_reg) begin
                    tmr_n = half_cyc;
                end else if (tmr_done) begin
                    sda_lo_n = 1'b0;
                    tmr_n    = half_cyc;
                    st_n     = TW_STOP3;
                end
            end
            TW_STOP3: begin
                if (tmr_done) begin
                    st_n     = TW_IDLE;
                    mst_n    = 1'b0;
                    sto_done = 1'b1; // RULE_09
                end
            end
            default: begin
                st_n = TW_IDLE;
            end
        endcase
        if (ctl_reg.sto && !mst_reg) begin // RULE_10
            st_n     = TW_IDLE;
            slv_n    = 1'b0;
            adr_ph_n = 1'b0;
            scl_lo_n = 1'b0;
            sda_lo_n = 1'b0;
            set_flag = 1'b0;
            sto_done = 1'b1;
        end
        if (!ctl_reg.en) begin // RULE_12
            st_n     = TW_IDLE;
            mst_n    = 1'b0;
            slv_n    = 1'b0;
            adr_ph_n = 1'b0;
            scl_lo_n = 1'b0;
            sda_lo_n = 1'b0;
            set_flag = 1'b0;
        end
    end

    // ----------------------------------------
    // State registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            brd_reg    <= `TW_RST_BYTE; // RULE_25
            ctl_reg    <= '0;
            ps_reg     <= 2'h0;
            code_reg   <= `TW_SC_NONE;
            evt_reg    <= `TW_SC_NONE;
            dat_reg    <= `TW_RST_BYTE;
            adr_reg    <= `TW_RST_BYTE;
            msk_reg    <= 7'h00;
            rdata_reg  <= 8'h00;
            irq_reg    <= 1'b0;
            zero_reg   <= 1'b0;
        end else begin
            brd_reg    <= wr_brd ? wd : brd_reg;
            ctl_reg    <= ctl_next;
            ps_reg     <= wr_sts ? wd[1:0] : ps_reg;
            code_reg   <= ctl_reg.flag ? evt_reg : `TW_SC_NONE; // RULE_23
            evt_reg    <= set_flag ? set_code : evt_reg;
            dat_reg    <= dat_next;
            adr_reg    <= wr_adr ? wd : adr_reg;
            msk_reg    <= wr_msk ? wd[7:1] : msk_reg;
            rdata_reg  <= rdata_next;
            irq_reg    <= flag_next & ctl_next.ie & gie; // RULE_02 RULE_13
            zero_reg   <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg     <= TW_IDLE;
            mst_reg    <= 1'b0;
            slv_reg    <= 1'b0;
            tx_reg     <= 1'b0;
            adr_ph_reg <= 1'b0;
            gc_reg     <= 1'b0;
            lost_reg   <= 1'b0;
            rs_reg     <= 1'b0;
            ackrx_reg  <= 1'b1;
            cnt_reg    <= 4'h0;
            tmr_reg    <= 15'h0000;
            scl_lo_reg <= 1'b0;
            sda_lo_reg <= 1'b0;
        end else begin
            st_reg     <= st_n;
            mst_reg    <= mst_n;
            slv_reg    <= slv_n;
            tx_reg     <= tx_n;
            adr_ph_reg <= adr_ph_n;
            gc_reg     <= gc_n;
            lost_reg   <= lost_n;
            rs_reg     <= rs_n;
            ackrx_reg  <= ackrx_n;
            cnt_reg    <= cnt_n;
            tmr_reg    <= tmr_n;
            scl_lo_reg <= scl_lo_n;
            sda_lo_reg <= sda_lo_n;
        end
    end

    assign rdata   = rdata_reg;
    assign irq     = irq_reg;
    assign scl_out = zero_reg;
    assign sda_out = zero_reg;
    assign scl_oe  = scl_lo_reg;
    assign sda_oe  = sda_lo_reg;

endmodule
`default_nettype wire

// ---- hw/tw_pkg.sv ----
`default_nettype none
package tw_pkg;
    typedef enum logic [2:0] {
        TW_IDLE, TW_START, TW_RSTART, TW_BYTE, TW_HOLD, TW_STOP1, TW_STOP2, TW_STOP3
    } tw_state_t;

    typedef struct packed {
        logic       wr;
        logic [2:0] idx;
        logic [7:0] wdata;
    } tw_req_t;

    typedef struct packed {
        logic flag;
        logic ack;
        logic sta;
        logic sto;
        logic wc;
        logic en;
        logic ie;
    } tw_ctl_t;
endpackage
`default_nettype wire

// ---- hw/tw_regs.svh ----
`ifndef TW_REGS_SVH
`define TW_REGS_SVH
// What this block does
// RULE_01: The bit-rate divider register sets the master serial clock division factor.
// RULE_02: Job-done flag sets when an operation ends; interrupt needs both enables.
// RULE_03: Serial clock is held low while the job-done flag is set.
// RULE_04: Software clears job-done by writing one; hardware never auto-clears it.
// RULE_05: Clearing job-done starts the next bus operation.
// RULE_06: With ack enable set, acknowledge own address, general call or received data.
// RULE_07: With ack enable clear, own address is not recognised.
// RULE_08: Start request issues START when bus free, else after STOP; software clears it.
// RULE_09: Stop request as master sends STOP, then clears itself.
// RULE_10: Stop request as slave returns to unaddressed idle and releases both lines.
// RULE_11: Data write with job-done low sets collision flag; with job-done high clears it.
// RULE_12: Enable gives pin control; clearing it aborts any transfer at once.
// RULE_13: Interrupt request follows job-done exactly while both enables are set.
// RULE_14: Status holds 5-bit code in 7..3, prescale in 1..0, bit 2 zero.
// RULE_15: Software masks prescale bits before comparing status codes.
// RULE_16: Prescale codes 0..3 select bit-rate prescale 1, 4, 16 or 64.
// RULE_17: Data register writable only while job-done set; stable while it is set.
// RULE_18: Bus value shifts into data register while a byte shifts out.
// RULE_19: Lost arbitration falls back to slave keeping data; ACK handled internally.
// RULE_20: Received address compared with own 7-bit address in bits 7..1.
// RULE_21: Address bit 0 enables general call 0x00; any match sets job-done.
// RULE_22: Each set mask bit excludes that address bit from the comparison.
// RULE_23: Status loads the event code one cycle after job-done; else no-info code.
// RULE_24: Serial clock period is 16 plus twice divider times four to the prescale.
// RULE_25: All writable bits reset to zero; interface disabled and idle.

`define TW_IDX_BRD      3'h0
`define TW_IDX_CTL      3'h1
`define TW_IDX_STS      3'h2
`define TW_IDX_DAT      3'h3
`define TW_IDX_ADR      3'h4
`define TW_IDX_MSK      3'h5
`define TW_CTL_FLAG     7
`define TW_CTL_ACK      6
`define TW_CTL_STA      5
`define TW_CTL_STO      4
`define TW_CTL_EN       2
`define TW_CTL_IE       0
`define TW_RST_BYTE     8'h00
`define TW_HALF_FIXED   15'h0008
`define TW_SC_BUS_ERR   5'h00
`define TW_SC_START     5'h01
`define TW_SC_RSTART    5'h02
`define TW_SC_MT_SLA_A  5'h03
`define TW_SC_MT_SLA_N  5'h04
`define TW_SC_MT_DAT_A  5'h05
`define TW_SC_MT_DAT_N  5'h06
`define TW_SC_ARB_LOST  5'h07
`define TW_SC_MR_SLA_A  5'h08
`define TW_SC_MR_SLA_N  5'h09
`define TW_SC_MR_DAT_A  5'h0a
`define TW_SC_MR_DAT_N  5'h0b
`define TW_SC_SR_SLA    5'h0c
`define TW_SC_SR_GC     5'h0e
`define TW_SC_SR_DAT_A  5'h10
`define TW_SC_SR_DAT_N  5'h11
`define TW_SC_SR_STOP   5'h14
`define TW_SC_ST_SLA    5'h15
`define TW_SC_ST_DAT_A  5'h17
`define TW_SC_ST_DAT_N  5'h18
`define TW_SC_NONE      5'h1f
`endif

// ---- verification/tw_bus_model.sv ----
`default_nettype none
module tw_bus_model (
    // Clock and control
    input  wire logic  clk,
    input  wire logic  rst_n,
    input  wire logic  stretch,
    // Device pull-downs and resolved lines
    input  wire logic  scl_oe,
    input  wire logic  sda_oe,
    output logic       scl_line,
    output logic       sda_line,
    output logic [7:0] rx_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       scl_d;
    logic       sda_d;
    logic       sda_pull;
    logic [3:0] bits;
    logic [3:0] hold;
    // Wired-AND with pull-ups: a released line floats high.
    assign scl_line = ~(scl_oe | (hold != 4'h0));
    assign sda_line = ~(sda_oe | sda_pull);
    always_ff @(posedge clk) begin
        scl_d <= scl_line;
        sda_d <= sda_line;
        if (!rst_n) begin
            bits     <= 4'h0;
            hold     <= 4'h0;
            sda_pull <= 1'b0;
            rx_byte  <= 8'h00;
        end else if (scl_line && sda_d && !sda_line) begin
            bits <= 4'h0;
        end else if (scl_line && !scl_d) begin
            bits    <= bits + 4'h1;
            rx_byte <= (bits < 4'h8) ? {rx_byte[6:0], sda_line} : rx_byte;
        end else if (!scl_line && scl_d) begin
            bits     <= (bits == 4'h9) ? 4'h0 : bits;
            sda_pull <= (bits == 4'h8);
            hold     <= stretch ? 4'hc : 4'h0;
        end else if (hold != 4'h0) begin
            hold <= hold - 4'h1;
        end
    end
endmodule
`default_nettype wire

// ---- verification/tw_core_properties.sv ----
`default_nettype none
module tw_core_properties
    import tw_pkg::*;
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // Register port
    input wire tw_req_t    req,
    input wire logic       gie,
    input wire logic [7:0] rdata,
    input wire logic       irq,
    // Bus pins
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       scl_out,
    input wire logic       scl_oe,
    input wire logic       sda_out,
    input wire logic       sda_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_ctl_seen;
        $past(req.idx, 2) == 3'h1 && $past(req.idx) == 3'h1 && !$past(req.wr);
    endsequence
    sequence s_start_cond;
        $rose(sda_oe) && !scl_oe && scl_in;
    endsequence
    property p_irq_gie;   !gie |=> !irq; endproperty
    property p_irq_clear; irq && req.wr && req.idx == 3'h1 && req.wdata[7] |=> !irq; endproperty
    property p_irq_hold;  irq && gie && !req.wr |=> irq; endproperty
    property p_irq_scl;   $rose(irq) && !$past(req.wr) |-> scl_oe; endproperty
    property p_stretch;
        s_ctl_seen ##0 (rdata[7] && rdata[2] && $past(rdata[7]) && $past(rdata[2])) |-> scl_oe;
    endproperty
    property p_disable;
        s_ctl_seen ##0 (!rdata[2] && !$past(rdata[2])) |-> !scl_oe && !sda_oe;
    endproperty
    property p_sts_res;   $past(req.idx) == 3'h2 |-> !rdata[2]; endproperty
    property p_start;     s_start_cond |-> !scl_oe [*7]; endproperty
    property p_open_drain; !scl_out && !sda_out; endproperty
    a_irq_gie:    assert property (p_irq_gie) else $error("irq without gie");
    a_irq_clear:  assert property (p_irq_clear) else $error("irq kept after clear");
    a_irq_hold:   assert property (p_irq_hold) else $error("irq dropped alone");
    a_irq_scl:    assert property (p_irq_scl) else $error("flag without hold");
    a_stretch:    assert property (p_stretch) else $error("clock not held low");
    a_disable:    assert property (p_disable) else $error("driven while off");
    a_sts_res:    assert property (p_sts_res) else $error("status bit 2 set");
    a_start:      assert property (p_start) else $error("start setup short");
    a_open_drain: assert property (p_open_drain) else $error("line driven high");
endmodule
bind tw_core tw_core_properties u_props (.clk, .rst_n, .req, .gie, .rdata, .irq, .scl_in,
    .sda_in, .scl_out, .scl_oe, .sda_out, .sda_oe);
`default_nettype wire

// ---- verification/two_wire_serial_register_control_tb.sv ----
`default_nettype none
module two_wire_serial_register_control_tb
    import tw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk, rst_n, gie, irq, stretch;
    logic       scl_line, sda_line, scl_out, scl_oe, sda_out, sda_oe;
    logic [7:0] rdata, rx_byte, v;
    tw_req_t    req;
    int         miscompares = 0;
    int         n_tests = 0;
    tw_core dut (.clk, .rst_n, .req, .gie, .rdata, .irq, .scl_in(scl_line), .sda_in(sda_line),
        .scl_out, .scl_oe, .sda_out, .sda_oe);
    tw_bus_model u_bus (.clk, .rst_n, .stretch, .scl_oe, .sda_oe, .scl_line, .sda_line,
        .rx_byte);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [2:0] i, input logic [7:0] d);
        req <= '{wr: 1'b1, idx: i, wdata: d};
        @(posedge clk);
        req.wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [2:0] i, output logic [7:0] d);
        req.idx <= i;
        repeat (2) @(posedge clk);
        @(negedge clk);
        d = rdata;
        @(posedge clk);
    endtask
    // Polls for flag set, or with s for stop clear.
    task automatic wait_ctl(input logic s);
        for (int n = 0; n < 1000; n++) begin
            rd(3'h1, v);
            if (s ? !v[4] : v[7]) return;
        end
        miscompares++;
        $display("[FAIL] %0t wait ran out", $time);
        summarize();
    endtask
    task automatic t_reset();
        for (int i = 0; i < 6; i++) begin
            rd(i[2:0], v);
            chk(v, (i == 2) ? 8'hf8 : 8'h00);
        end
        $display("reset done");
    endtask
    task automatic t_regs();
        wr(3'h0, 8'hff);
        wr(3'h2, 8'hff);
        wr(3'h4, 8'hff);
        wr(3'h5, 8'hff);
        wr(3'h3, 8'h5a);
        rd(3'h0, v); chk(v, 8'hff);
        rd(3'h2, v); chk(v, 8'hfb);
        rd(3'h4, v); chk(v, 8'hff);
        rd(3'h5, v); chk(v, 8'hfe);
        rd(3'h3, v); chk(v, 8'h00);
        rd(3'h1, v); chk(v, 8'h08);
        wr(3'h5, 8'h00);
        wr(3'h0, 8'h01);
        $display("regs done");
    endtask
    task automatic t_xfer(input logic [1:0] ps);
        int c;
        stretch <= ps[0];
        wr(3'h2, {6'h00, ps});
        wr(3'h1, 8'ha5);
        wait_ctl(1'b0);
        rd(3'h2, v); chk(v, {5'h01, 1'b0, ps});
        chk({7'h00, irq}, 8'h01);
        wr(3'h3, 8'ha6);
        rd(3'h1, v); chk(v, 8'ha5);
        wr(3'h1, 8'h85);
        c = 0;
        while (scl_oe === 1'b1 && c < 999) begin @(negedge clk); c++; end
        while (scl_oe !== 1'b1 && c < 999) begin @(negedge clk); c++; end
        c = 0;
        while (scl_oe === 1'b1 && c < 999) begin c++; @(negedge clk); end
        chk(c[7:0], 8'h08 + (8'h01 << (2 * ps)));
        @(posedge clk);
        wait_ctl(1'b0);
        rd(3'h2, v); chk(v, {5'h03, 1'b0, ps});
        chk(v & 8'hf8, 8'h18);
        chk(rx_byte, 8'ha6);
        rd(3'h3, v); chk(v, 8'ha6);
        wr(3'h1, 8'h95);
        wait_ctl(1'b1);
        chk(v, 8'h05);
        rd(3'h2, v); chk(v, {5'h1f, 1'b0, ps});
        $display("xfer ps %0d done", ps);
    endtask
    task automatic t_abort();
        wr(3'h2, 8'h00);
        wr(3'h1, 8'ha4);
        wait_ctl(1'b0);
        wr(3'h3, 8'hff);
        wr(3'h1, 8'h84);
        repeat (20) @(posedge clk);
        wr(3'h1, 8'h00);
        rd(3'h1, v); chk(v, 8'h00);
        @(negedge clk);
        chk({6'h00, scl_oe, sda_oe}, 8'h00);
        @(posedge clk);
        $display("abort done");
    endtask
    initial begin
        rst_n = 1'b0;
        gie = 1'b0;
        stretch = 1'b0;
        req = '0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_regs();
        gie <= 1'b1;
        for (int p = 0; p < 4; p++) t_xfer(p[1:0]);
        t_abort();
        summarize();
    end
endmodule
`default_nettype wire
